/* File: design/addr_stack.sv */
`timescale 1ns/1ps
// address stack, pre-decrement push and post-increment pop
module addr_stack #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 16,
  parameter int SP_W = 3
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic sync_clear_i,
  // operations
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic [WIDTH-1:0] push_data_i,
  // state
  output logic [WIDTH-1:0] top_o,
  output logic [SP_W-1:0] sp_o
);
  logic [WIDTH-1:0] entry_reg [DEPTH];
  logic [SP_W-1:0] sp_dec;

  assign sp_dec = sp_o - 1'b1;
  assign top_o = entry_reg[sp_o];

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sp_o <= sysreg_pkg::SP_RESET;
    end else if (sync_clear_i) begin
      sp_o <= sysreg_pkg::SP_RESET;
    end else if (push_i) begin
      sp_o <= sp_dec;
    end else if (pop_i) begin
      sp_o <= sp_o + 1'b1;
    end
  end

  // stack contents are not cleared by reset
  always_ff @(posedge core_clk_i) begin
    if (push_i) begin
      entry_reg[sp_dec] <= push_data_i; // written at the decremented index
    end
  end
endmodule // addr_stack

/* File: design/prog_addr_pointer.sv */
`timescale 1ns/1ps
// 16-bit pointer with nibble writes, load and wrapping increment
module prog_addr_pointer #(
  parameter int PTR_W = 16
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic sync_clear_i,
  // nibble write
  input wire logic nib_we_i,
  input wire logic [1:0] nib_sel_i,
  input wire logic [3:0] nib_data_i,
  // whole-word load and increment
  input wire logic load_i,
  input wire logic [PTR_W-1:0] load_data_i,
  input wire logic incr_i,
  // state
  output logic [PTR_W-1:0] ptr_o
);
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ptr_o <= sysreg_pkg::PTR_RESET;
    end else if (sync_clear_i) begin
      ptr_o <= sysreg_pkg::PTR_RESET;
    end else if (load_i) begin
      ptr_o <= load_data_i;
    end else if (incr_i) begin
      ptr_o <= ptr_o + 1'b1; // all-ones wraps to zero, no flag
    end else if (nib_we_i) begin
      // nibble 0 is the most significant one
      ptr_o[PTR_W-1-4*nib_sel_i -: 4] <= nib_data_i;
    end
  end
endmodule // prog_addr_pointer

/* File: design/sysreg_pkg.sv */
package sysreg_pkg;
  // ----------------------------------------
  // data-memory geometry
  // ----------------------------------------
  localparam int DM_ADDR_W = 7;
  localparam int BANK_W = 4;
  localparam int NIB_W = 4;
  localparam int PTR_W = 16;
  localparam int PM_W = 16;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;

  // ----------------------------------------
  // system register offsets
  // ----------------------------------------
  localparam logic [6:0] SYSREG_FIRST = 7'h74;
  localparam logic [6:0] SYSREG_LAST = 7'h7F;
  localparam logic [6:0] OFS_PA_HIGH = 7'h74;
  localparam logic [6:0] OFS_PA_UPPER_MID = 7'h75;
  localparam logic [6:0] OFS_PA_LOWER_MID = 7'h76;
  localparam logic [6:0] OFS_PA_LOW = 7'h77;
  localparam logic [6:0] OFS_WINDOW = 7'h78;
  localparam logic [6:0] OFS_BANK = 7'h79;
  localparam logic [6:0] OFS_IDX_ROW_HIGH = 7'h7A;
  localparam logic [6:0] OFS_IDX_ROW_MID = 7'h7B;
  localparam logic [6:0] OFS_IDX_LOW = 7'h7C;
  localparam logic [6:0] OFS_GRP_HIGH = 7'h7D;
  localparam logic [6:0] OFS_GRP_LOW = 7'h7E;
  localparam logic [6:0] OFS_STATUS_NIB = 7'h7F;

  // constant data buffer, bank zero
  localparam logic [3:0] CDB_BANK = 4'h0;
  localparam logic [6:0] CDB_FIRST = 7'h0C;
  localparam logic [6:0] CDB_LAST = 7'h0F;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [3:0] NIB_RESET = 4'h0;
  localparam logic [2:0] SP_RESET = 3'h0;
  localparam logic [15:0] PM_TOP_DEFAULT = 16'h3FFF;

  // ----------------------------------------
  // pointer operations
  // ----------------------------------------
  typedef enum logic [5:0] {
    OP_NONE = 6'h01,
    OP_TABLE_READ = 6'h02,
    OP_PUSH = 6'h04,
    OP_POP = 6'h08,
    OP_BRANCH = 6'h10,
    OP_CALL = 6'h20
  } ptr_op_t;
endpackage

/* File: design/system_register_address_pointer.sv */
`timescale 1ns/1ps
module system_register_address_pointer #(
  parameter logic [15:0] PM_TOP = sysreg_pkg::PM_TOP_DEFAULT,
  parameter int STACK_DEPTH = sysreg_pkg::STACK_DEPTH
) (
  // clock and resets
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic watchdog_stack_reset_i,
  input wire logic chip_enable_reset_i,
  // data-memory port
  input wire logic dm_we_i,
  input wire logic dm_re_i,
  input wire logic [3:0] dm_bank_i,
  input wire logic [6:0] dm_addr_i,
  input wire logic [3:0] dm_wdata_i,
  output logic [3:0] dm_rdata_o,
  output logic dm_hit_o,
  // sequencer operations
  input wire logic op_valid_i,
  input wire sysreg_pkg::ptr_op_t op_i,
  input wire logic pointer_increment_op_i,
  // program memory read for table reads
  output logic pm_req_o,
  output logic [15:0] pm_addr_o,
  input wire logic pm_ack_i,
  input wire logic [15:0] pm_rdata_i,
  // results
  output logic [15:0] constant_data_buffer_o,
  output logic cdb_valid_o,
  output logic jump_o,
  output logic call_o,
  output logic [15:0] jump_target_o,
  output logic [15:0] prog_addr_pointer_o,
  output logic [3:0] data_bank_select_o,
  output logic [2:0] stack_pointer_o,
  output logic [6:0] row_pointer_o,
  output logic [10:0] index_offset_o,
  output logic range_error_o
);
  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic sync_clear;
  logic sys_hit;
  logic cdb_hit;
  logic [1:0] cdb_nib;
  logic [3:0] sys_idx;
  logic ptr_nib_we;
  logic [15:0] ptr_q;
  logic [15:0] stack_top;
  logic [2:0] sp_q;
  logic pop_go;
  logic push_go;
  logic tr_start;
  logic in_range;
  logic [3:0] window_reg;
  logic [3:0] bank_reg;
  logic [3:0] idx_high_reg;
  logic [3:0] idx_mid_reg;
  logic [3:0] idx_low_reg;
  logic [3:0] grp_high_reg;
  logic [3:0] grp_low_reg;
  logic [3:0] status_nib_reg;
  logic [15:0] cdb_reg;
  logic tr_busy_reg;
  logic op_table;
  logic op_branch;
  logic op_call;
  logic op_jump;
  logic [3:0] dm_rdata_next;
  logic dm_hit_next;

  assign sync_clear = watchdog_stack_reset_i | chip_enable_reset_i;
  // bank is ignored inside the system window
  assign sys_hit = (dm_addr_i >= sysreg_pkg::SYSREG_FIRST) && (dm_addr_i <= sysreg_pkg::SYSREG_LAST);
  assign cdb_hit = (dm_bank_i == sysreg_pkg::CDB_BANK) && (dm_addr_i >= sysreg_pkg::CDB_FIRST)
                   && (dm_addr_i <= sysreg_pkg::CDB_LAST);
  assign cdb_nib = 2'(dm_addr_i - sysreg_pkg::CDB_FIRST);
  assign sys_idx = 4'(dm_addr_i - sysreg_pkg::SYSREG_FIRST);
  assign ptr_nib_we = dm_we_i && sys_hit && (dm_addr_i <= sysreg_pkg::OFS_PA_LOW);
  assign push_go = op_valid_i && (op_i == sysreg_pkg::OP_PUSH);
  assign pop_go = op_valid_i && (op_i == sysreg_pkg::OP_POP);
  assign op_table = op_valid_i && (op_i == sysreg_pkg::OP_TABLE_READ);
  assign op_branch = op_valid_i && (op_i == sysreg_pkg::OP_BRANCH);
  assign op_call = op_valid_i && (op_i == sysreg_pkg::OP_CALL);
  assign op_jump = op_branch || op_call;
  assign tr_start = op_table && !tr_busy_reg;
  assign in_range = (ptr_q <= PM_TOP);

  // ----------------------------------------
  // pointer and stack
  // ----------------------------------------
  prog_addr_pointer #(
    .PTR_W(sysreg_pkg::PTR_W)
  ) u_ptr (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .sync_clear_i(sync_clear),
    .nib_we_i(ptr_nib_we),
    .nib_sel_i(sys_idx[1:0]),
    .nib_data_i(dm_wdata_i),
    .load_i(pop_go),
    .load_data_i(stack_top),
    .incr_i(pointer_increment_op_i),
    .ptr_o(ptr_q)
  );

  addr_stack #(
    .DEPTH(STACK_DEPTH),
    .WIDTH(sysreg_pkg::PTR_W),
    .SP_W(sysreg_pkg::SP_W)
  ) u_stack (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .sync_clear_i(watchdog_stack_reset_i),
    .push_i(push_go),
    .pop_i(pop_go),
    .push_data_i(ptr_q),
    .top_o(stack_top),
    .sp_o(sp_q)
  );

  // ----------------------------------------
  // other system registers
  // ----------------------------------------
  // window register keeps its value over every reset
  always_ff @(posedge core_clk_i) begin
    if (dm_we_i && sys_hit && dm_addr_i == sysreg_pkg::OFS_WINDOW) begin
      window_reg <= dm_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      bank_reg <= sysreg_pkg::NIB_RESET;
    end else if (sync_clear) begin
      bank_reg <= sysreg_pkg::NIB_RESET;
    end else if (dm_we_i && sys_hit && dm_addr_i == sysreg_pkg::OFS_BANK) begin
      bank_reg <= dm_wdata_i; // written from any bank
    end
  end

  // index and row pointer are one store, so the two views can never disagree
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      idx_high_reg <= sysreg_pkg::NIB_RESET;
      idx_mid_reg <= sysreg_pkg::NIB_RESET;
      idx_low_reg <= sysreg_pkg::NIB_RESET;
    end else if (sync_clear) begin
      idx_high_reg <= sysreg_pkg::NIB_RESET;
      idx_mid_reg <= sysreg_pkg::NIB_RESET;
      idx_low_reg <= sysreg_pkg::NIB_RESET;
    end else if (dm_we_i && sys_hit && dm_addr_i == sysreg_pkg::OFS_IDX_ROW_HIGH) begin
      idx_high_reg <= dm_wdata_i; // shared storage
    end else if (dm_we_i && sys_hit && dm_addr_i == sysreg_pkg::OFS_IDX_ROW_MID) begin
      idx_mid_reg <= dm_wdata_i;
    end else if (dm_we_i && sys_hit && dm_addr_i == sysreg_pkg::OFS_IDX_LOW) begin
      idx_low_reg <= dm_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      grp_high_reg <= sysreg_pkg::NIB_RESET;
      grp_low_reg <= sysreg_pkg::NIB_RESET;
    end else if (sync_clear) begin
      grp_high_reg <= sysreg_pkg::NIB_RESET;
      grp_low_reg <= sysreg_pkg::NIB_RESET;
    end else if (dm_we_i && sys_hit && dm_addr_i == sysreg_pkg::OFS_GRP_HIGH) begin
      grp_high_reg <= dm_wdata_i;
    end else if (dm_we_i && sys_hit && dm_addr_i == sysreg_pkg::OFS_GRP_LOW) begin
      grp_low_reg <= dm_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      status_nib_reg <= sysreg_pkg::NIB_RESET;
    end else if (sync_clear) begin
      status_nib_reg <= sysreg_pkg::NIB_RESET;
    end else if (dm_we_i && sys_hit && dm_addr_i == sysreg_pkg::OFS_STATUS_NIB) begin
      status_nib_reg <= dm_wdata_i;
    end
  end

  // ----------------------------------------
  // table read into the constant data buffer
  // ----------------------------------------
  // one outstanding fetch; a second request while busy is dropped
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tr_busy_reg <= 1'b0;
      pm_req_o <= 1'b0;
      pm_addr_o <= sysreg_pkg::PTR_RESET;
      cdb_valid_o <= 1'b0;
    end else begin
      cdb_valid_o <= 1'b0;
      if (tr_start) begin
        tr_busy_reg <= 1'b1;
        pm_req_o <= 1'b1;
        pm_addr_o <= ptr_q;
      end else if (tr_busy_reg && pm_ack_i) begin
        tr_busy_reg <= 1'b0;
        pm_req_o <= 1'b0;
        cdb_valid_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cdb_reg <= sysreg_pkg::PTR_RESET;
    end else if (tr_busy_reg && pm_ack_i) begin
      cdb_reg <= pm_rdata_i;
    end else if (dm_we_i && cdb_hit) begin
      cdb_reg[15-4*cdb_nib -: 4] <= dm_wdata_i;
    end
  end

  // ----------------------------------------
  // branch, call and range check
  // ----------------------------------------
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      jump_o <= 1'b0;
      call_o <= 1'b0;
    end else begin
      jump_o <= op_jump;
      call_o <= op_call;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      jump_target_o <= sysreg_pkg::PTR_RESET;
    end else if (op_jump) begin
      jump_target_o <= ptr_q;
    end
  end

  // flag only; an out-of-range target is still issued
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      range_error_o <= 1'b0;
    end else begin
      range_error_o <= (op_jump || op_table) && !in_range;
    end
  end

  // ----------------------------------------
  // data-memory read port
  // ----------------------------------------
  always_comb begin
    dm_hit_next = dm_re_i && (sys_hit || cdb_hit);
    dm_rdata_next = sysreg_pkg::NIB_RESET;
    if (dm_re_i && cdb_hit) begin
      dm_rdata_next = cdb_reg[15-4*cdb_nib -: 4];
    end else if (dm_re_i && sys_hit) begin
      unique case (dm_addr_i)
        sysreg_pkg::OFS_PA_HIGH: dm_rdata_next = ptr_q[15:12];
        sysreg_pkg::OFS_PA_UPPER_MID: dm_rdata_next = ptr_q[11:8];
        sysreg_pkg::OFS_PA_LOWER_MID: dm_rdata_next = ptr_q[7:4];
        sysreg_pkg::OFS_PA_LOW: dm_rdata_next = ptr_q[3:0];
        sysreg_pkg::OFS_WINDOW: dm_rdata_next = window_reg;
        sysreg_pkg::OFS_BANK: dm_rdata_next = bank_reg;
        sysreg_pkg::OFS_IDX_ROW_HIGH: dm_rdata_next = idx_high_reg;
        sysreg_pkg::OFS_IDX_ROW_MID: dm_rdata_next = idx_mid_reg;
        sysreg_pkg::OFS_IDX_LOW: dm_rdata_next = idx_low_reg;
        sysreg_pkg::OFS_GRP_HIGH: dm_rdata_next = grp_high_reg;
        sysreg_pkg::OFS_GRP_LOW: dm_rdata_next = grp_low_reg;
        sysreg_pkg::OFS_STATUS_NIB: dm_rdata_next = status_nib_reg;
        default: dm_rdata_next = sysreg_pkg::NIB_RESET;
      endcase
    end
  end

  // registered so that a read answer appears one cycle after the read strobe, for as long as the strobe was held
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      dm_rdata_o <= sysreg_pkg::NIB_RESET;
      dm_hit_o <= 1'b0;
    end else begin
      dm_rdata_o <= dm_rdata_next;
      dm_hit_o <= dm_hit_next;
    end
  end

  // ----------------------------------------
  // state mirrors
  // ----------------------------------------
  // mirrors trail the internal state by one cycle so every output is a flip-flop
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      prog_addr_pointer_o <= sysreg_pkg::PTR_RESET;
      stack_pointer_o <= sysreg_pkg::SP_RESET;
    end else begin
      prog_addr_pointer_o <= ptr_q;
      stack_pointer_o <= sp_q;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      constant_data_buffer_o <= sysreg_pkg::PTR_RESET;
    end else begin
      constant_data_buffer_o <= cdb_reg;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      data_bank_select_o <= sysreg_pkg::NIB_RESET;
    end else begin
      data_bank_select_o <= bank_reg;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      row_pointer_o <= 7'h00;
      index_offset_o <= 11'h000;
    end else begin
      row_pointer_o <= {idx_high_reg[2:0], idx_mid_reg}; // same bits as index top
      index_offset_o <= {idx_high_reg[2:0], idx_mid_reg, idx_low_reg};
    end
  end
endmodule // system_register_address_pointer

/* File: tb/system_register_address_pointer_sva.sv */
`timescale 1ns/1ps
module system_register_address_pointer_chk #(
  parameter logic [15:0] PM_TOP = 16'h3FFF
) (
  // clock and resets
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic watchdog_stack_reset_i,
  // data-memory port
  input wire logic dm_re_i,
  input wire logic [3:0] dm_bank_i,
  input wire logic [6:0] dm_addr_i,
  input wire logic [3:0] dm_rdata_o,
  input wire logic dm_hit_o,
  // operations and results
  input wire logic op_valid_i,
  input wire sysreg_pkg::ptr_op_t op_i,
  input wire logic pm_req_o,
  input wire logic [15:0] pm_addr_o,
  input wire logic pm_ack_i,
  input wire logic cdb_valid_o,
  input wire logic jump_o,
  input wire logic call_o,
  input wire logic [15:0] jump_target_o,
  input wire logic range_error_o,
  input wire logic [15:0] prog_addr_pointer_o,
  input wire logic [2:0] stack_pointer_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  // ----------------------------------------
  // data port
  // ----------------------------------------
  a_sysreg_read_hit: assert property (dm_re_i && dm_addr_i >= 7'h74 |=> dm_hit_o)
    else $error("system register read did not hit");
  a_unmapped_read_zero: assert property (dm_re_i && dm_addr_i < 7'h74
      && !(dm_bank_i == 4'h0 && dm_addr_i inside {[7'h0C:7'h0F]}) |=> !dm_hit_o && dm_rdata_o == 4'h0)
    else $error("unmapped read returned a hit or data");

  // ----------------------------------------
  // branch and call
  // ----------------------------------------
  a_branch_jump_pulse: assert property (op_valid_i && op_i == sysreg_pkg::OP_BRANCH |=> jump_o && !call_o)
    else $error("indirect branch gave no jump");
  a_call_jump_pulse: assert property (op_valid_i && op_i == sysreg_pkg::OP_CALL |=> jump_o && call_o)
    else $error("indirect call gave no call");
  a_jump_range_flag: assert property (jump_o |-> range_error_o == (jump_target_o > PM_TOP))
    else $error("range flag disagrees with jump target");

  // ----------------------------------------
  // table read handshake
  // ----------------------------------------
  a_table_req_start: assert property (op_valid_i && op_i == sysreg_pkg::OP_TABLE_READ && !pm_req_o
      && !cdb_valid_o |=> pm_req_o)
    else $error("table read raised no request");
  a_req_held_stable: assert property (pm_req_o && !pm_ack_i |=> pm_req_o && $stable(pm_addr_o))
    else $error("request dropped or address moved before ack");
  a_ack_loads_buffer: assert property (pm_req_o && pm_ack_i |=> !pm_req_o && cdb_valid_o ##1 !cdb_valid_o)
    else $error("ack did not complete the table read");

  // ----------------------------------------
  // sync clear
  // ----------------------------------------
  a_wdog_clears_ptr: assert property (watchdog_stack_reset_i |-> ##2 prog_addr_pointer_o == 16'h0000
      && stack_pointer_o == 3'h0)
    else $error("watchdog clear left pointer or stack set");

  c_table_done: cover property (pm_req_o && pm_ack_i);
  c_call_taken: cover property (call_o);
  c_out_of_range: cover property (jump_o && range_error_o);
endmodule // system_register_address_pointer_chk

bind system_register_address_pointer system_register_address_pointer_chk #(.PM_TOP(PM_TOP)) u_chk (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .watchdog_stack_reset_i(watchdog_stack_reset_i),
  .dm_re_i(dm_re_i), .dm_bank_i(dm_bank_i), .dm_addr_i(dm_addr_i), .dm_rdata_o(dm_rdata_o),
  .dm_hit_o(dm_hit_o), .op_valid_i(op_valid_i), .op_i(op_i), .pm_req_o(pm_req_o), .pm_addr_o(pm_addr_o),
  .pm_ack_i(pm_ack_i), .cdb_valid_o(cdb_valid_o), .jump_o(jump_o), .call_o(call_o),
  .jump_target_o(jump_target_o), .range_error_o(range_error_o),
  .prog_addr_pointer_o(prog_addr_pointer_o), .stack_pointer_o(stack_pointer_o));

/* File: tb/system_register_address_pointer_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin error_cnt++; \
  $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module system_register_address_pointer_tb;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic watchdog_stack_reset_i = 1'b0, chip_enable_reset_i = 1'b0;
  logic dm_we_i = 1'b0, dm_re_i = 1'b0, op_valid_i = 1'b0, pointer_increment_op_i = 1'b0, pm_ack_i = 1'b0;
  logic [3:0] dm_bank_i = 4'h0, dm_wdata_i = 4'h0, dm_rdata_o, data_bank_select_o, rd_nib;
  logic [6:0] dm_addr_i = 7'h00, row_pointer_o;
  sysreg_pkg::ptr_op_t op_i = sysreg_pkg::OP_NONE;
  logic [15:0] pm_rdata_i = 16'h0000, pm_addr_o, constant_data_buffer_o, jump_target_o, prog_addr_pointer_o, pv;
  logic dm_hit_o, pm_req_o, cdb_valid_o, jump_o, call_o, range_error_o, rd_hit;
  logic [2:0] stack_pointer_o;
  logic [10:0] index_offset_o;
  int error_cnt = 0;
  int n_checks = 0;

  always #5 core_clk_i = ~core_clk_i;

  system_register_address_pointer #(.PM_TOP(16'h3FFF), .STACK_DEPTH(8)) u_system_register_address_pointer (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .watchdog_stack_reset_i(watchdog_stack_reset_i),
    .chip_enable_reset_i(chip_enable_reset_i), .dm_we_i(dm_we_i), .dm_re_i(dm_re_i), .dm_bank_i(dm_bank_i),
    .dm_addr_i(dm_addr_i), .dm_wdata_i(dm_wdata_i), .dm_rdata_o(dm_rdata_o), .dm_hit_o(dm_hit_o),
    .op_valid_i(op_valid_i), .op_i(op_i), .pointer_increment_op_i(pointer_increment_op_i),
    .pm_req_o(pm_req_o), .pm_addr_o(pm_addr_o), .pm_ack_i(pm_ack_i), .pm_rdata_i(pm_rdata_i),
    .constant_data_buffer_o(constant_data_buffer_o), .cdb_valid_o(cdb_valid_o), .jump_o(jump_o),
    .call_o(call_o), .jump_target_o(jump_target_o), .prog_addr_pointer_o(prog_addr_pointer_o),
    .data_bank_select_o(data_bank_select_o), .stack_pointer_o(stack_pointer_o),
    .row_pointer_o(row_pointer_o), .index_offset_o(index_offset_o), .range_error_o(range_error_o));

  // ----------------------------------------
  // bus helpers, all driven at the falling edge
  // ----------------------------------------
  task automatic rd(input logic [3:0] bank, input logic [6:0] addr);
    dm_re_i = 1'b1;
    dm_bank_i = bank;
    dm_addr_i = addr;
    @(negedge core_clk_i);
    dm_re_i = 1'b0;
    rd_nib = dm_rdata_o;
    rd_hit = dm_hit_o;
    // idle edge so that back-to-back calls never toggle the strobe in one step
    @(negedge core_clk_i);
  endtask

  task automatic wr(input logic [3:0] bank, input logic [6:0] addr, input logic [3:0] data);
    dm_we_i = 1'b1;
    dm_bank_i = bank;
    dm_addr_i = addr;
    dm_wdata_i = data;
    @(negedge core_clk_i);
    dm_we_i = 1'b0;
    @(negedge core_clk_i);
  endtask

  // mirrors trail internal state, so give them two edges
  task automatic settle();
    repeat (2) @(negedge core_clk_i);
  endtask

  task automatic set_ptr(input logic [15:0] v);
    for (int i = 0; i < 4; i++) wr(4'h3, 7'h74 + 7'(i), v[15-4*i -: 4]);
    settle();
  endtask

  task automatic pulse(input sysreg_pkg::ptr_op_t o);
    op_valid_i = 1'b1;
    op_i = o;
    @(negedge core_clk_i);
    op_valid_i = 1'b0;
    op_i = sysreg_pkg::OP_NONE;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_values();
    for (int i = 0; i < 4; i++) begin
      rd(4'h5, 7'h74 + 7'(i));
      `CHK("ptr nibble after reset", 4'h0, rd_nib)
      `CHK("sysreg hit", 1'b1, rd_hit)
    end
  endtask

  task automatic t_nibbles();
    set_ptr(16'h1234);
    for (int i = 0; i < 4; i++) begin
      rd(4'h9, 7'h74 + 7'(i));
      pv = 16'h1234 >> (12 - 4 * i);
      `CHK("ptr nibble other bank", pv[3:0], rd_nib)
      `CHK("hit other bank", 1'b1, rd_hit)
    end
    `CHK("pointer mirror", 16'h1234, prog_addr_pointer_o)
    rd(4'h1, 7'h20);
    `CHK("unmapped hit", 1'b0, rd_hit)
    wr(4'h6, 7'h7A, 4'hD);
    wr(4'h6, 7'h7B, 4'h6);
    wr(4'h6, 7'h7C, 4'h5);
    settle();
    `CHK("row pointer", 7'h56, row_pointer_o)
    `CHK("index offset", 11'h565, index_offset_o)
    for (int i = 0; i < 8; i++) wr(4'hC, 7'h78 + 7'(i), 4'(15 - i));
    for (int i = 0; i < 8; i++) begin
      rd(4'h2, 7'h78 + 7'(i));
      `CHK("sysreg readback other bank", 4'(15 - i), rd_nib)
    end
    `CHK("bank select mirror", 4'hE, data_bank_select_o)
  endtask

  task automatic t_branch_call();
    for (int j = 0; j < 4; j++) begin
      pv = j[0] ? 16'h4000 : 16'h3FFF;
      set_ptr(pv);
      pulse(j[1] ? sysreg_pkg::OP_CALL : sysreg_pkg::OP_BRANCH);
      `CHK("jump", 1'b1, jump_o)
      `CHK("call", j[1], call_o)
      `CHK("jump target", pv, jump_target_o)
      `CHK("range error", j[0], range_error_o)
    end
  endtask

  task automatic t_increment();
    for (int j = 0; j < 2; j++) begin
      set_ptr(j[0] ? 16'h00FF : 16'hFFFF);
      pointer_increment_op_i = 1'b1;
      @(negedge core_clk_i);
      pointer_increment_op_i = 1'b0;
      settle();
      `CHK("incremented pointer", j[0] ? 16'h0100 : 16'h0000, prog_addr_pointer_o)
    end
    `CHK("no flag on wrap", 1'b0, range_error_o)
  endtask

  task automatic t_stack();
    set_ptr(16'h1234);
    pulse(sysreg_pkg::OP_PUSH);
    set_ptr(16'h5678);
    pulse(sysreg_pkg::OP_PUSH);
    settle();
    `CHK("sp after two pushes", 3'h6, stack_pointer_o)
    set_ptr(16'h0000);
    pulse(sysreg_pkg::OP_POP);
    settle();
    `CHK("first pop", 16'h5678, prog_addr_pointer_o)
    `CHK("sp after pop", 3'h7, stack_pointer_o)
    pulse(sysreg_pkg::OP_POP);
    settle();
    `CHK("second pop", 16'h1234, prog_addr_pointer_o)
    `CHK("sp restored", 3'h0, stack_pointer_o)
  endtask

  task automatic t_table();
    set_ptr(16'h0100);
    pulse(sysreg_pkg::OP_TABLE_READ);
    `CHK("pm request", 1'b1, pm_req_o)
    `CHK("pm address", 16'h0100, pm_addr_o)
    repeat (3) @(negedge core_clk_i);
    `CHK("request held in stall", 1'b1, pm_req_o)
    pm_ack_i = 1'b1;
    pm_rdata_i = 16'hBEEF;
    @(negedge core_clk_i);
    pm_ack_i = 1'b0;
    pm_rdata_i = 16'h4110;
    `CHK("buffer valid", 1'b1, cdb_valid_o)
    @(negedge core_clk_i);
    `CHK("buffer word", 16'hBEEF, constant_data_buffer_o)
    for (int i = 0; i < 4; i++) begin
      rd(4'h0, 7'h0C + 7'(i));
      pv = 16'hBEEF >> (12 - 4 * i);
      `CHK("buffer nibble", pv[3:0], rd_nib)
    end
    rd(4'h2, 7'h0C);
    `CHK("buffer absent in bank 2", 1'b0, rd_hit)
  endtask

  task automatic t_sync_resets();
    set_ptr(16'h1234);
    pulse(sysreg_pkg::OP_PUSH);
    chip_enable_reset_i = 1'b1;
    @(negedge core_clk_i);
    chip_enable_reset_i = 1'b0;
    settle();
    `CHK("ptr after chip enable clear", 16'h0000, prog_addr_pointer_o)
    `CHK("sp kept by chip enable clear", 3'h7, stack_pointer_o)
    set_ptr(16'h2222);
    watchdog_stack_reset_i = 1'b1;
    @(negedge core_clk_i);
    watchdog_stack_reset_i = 1'b0;
    settle();
    `CHK("ptr after watchdog clear", 16'h0000, prog_addr_pointer_o)
    `CHK("sp after watchdog clear", 3'h0, stack_pointer_o)
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (5) @(negedge core_clk_i);
    reset_i = 1'b0;
    @(negedge core_clk_i);
    t_reset_values();
    t_nibbles();
    t_branch_call();
    t_increment();
    t_stack();
    t_table();
    t_sync_resets();
    close_out();
  end

  // whole run is well under a thousand cycles
  initial begin
    #50000;
    error_cnt++;
    close_out();
  end
endmodule // system_register_address_pointer_tb
